// [shared/phy_np_status_pkg.sv]
// Package: register map, field positions and carrier structs for the page/status bank
package phy_np_status_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the management port
  // ---------------------------------------------------------------
  localparam logic [4:0]  NPT_ADDR           = 5'h07;
  localparam logic [4:0]  DLS_ADDR           = 5'h1c;

  // ---------------------------------------------------------------
  // Next-page transmit register fields
  // ---------------------------------------------------------------
  localparam int          NPT_NEXT_PAGE_BIT  = 15;
  localparam int          NPT_ACK_BIT        = 14;
  localparam int          NPT_MESSAGE_BIT    = 13;
  localparam int          NPT_COMPLY_BIT     = 12;
  localparam int          NPT_TOGGLE_BIT     = 11;
  localparam int          NPT_CODE_MSB       = 10;
  localparam logic [15:0] NPT_RESET          = 16'h0000;
  localparam logic [15:0] NPT_WRITE_MASK     = 16'hb7ff;

  // ---------------------------------------------------------------
  // Device link status register fields
  // ---------------------------------------------------------------
  localparam int          DLS_MISSING_DELIM  = 8;
  localparam int          DLS_CODE_VIOL      = 7;
  localparam int          DLS_POLARITY       = 6;
  localparam int          DLS_DISCONNECT     = 5;
  localparam int          DLS_UNLOCKED       = 4;
  localparam int          DLS_FALSE_CARRIER  = 3;
  localparam int          DLS_FORCED_JAM     = 2;
  localparam int          DLS_FAST_LINK      = 1;
  localparam int          DLS_SLOW_LINK      = 0;
  localparam int          NUM_LATCHED        = 6;
  localparam logic [15:0] DLS_RESET          = 16'h0000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Management access: one-cycle strobes with address and data
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_s;

  // Datapath event pulses, one cycle each, order matches latched bits 8,7,5,4,3,2
  typedef struct packed {
    logic missing_delimiter;
    logic code_violation;
    logic disconnect;
    logic scrambler_unlock;
    logic false_carrier;
    logic forced_jam;
  } dp_events_s;

  // Datapath levels
  typedef struct packed {
    logic speed_100;
    logic polarity_reversed;
    logic fast_link_up;
    logic slow_link_up;
    logic lcw_ack;
    logic lcw_toggle;
    logic page_exchanged;
    logic base_toggle;
    logic base_sent;
  } dp_levels_s;

endpackage

// [verilog/phy_next_page_and_status_regs.sv]
// Module: next-page transmit and device link status management registers
//
// Behaviour
// - Bit 15 next-page flag: 0 last page
// - Bit 14 shows acknowledge from link word
// - Bit 13 selects unformatted or message page
// - Bit 12 comply capability flag, writable
// - Bit 11 reads inverse of previous toggle
// - First next page toggle inverts base bit11
// - Bits 10:0 writable eleven-bit code field
// - Missing delimiter sets bit 8 at 10M
// - Latched error flags clear on read/reset
// - Manchester violation sets bit 7 at 10M
// - Bit 6 polarity reversal at 10M when fix enabled
// - Disconnect latches bit 5 at 100M
// - Scrambler unlock latches bit 4 at 100M
// - False carrier latches bit 3 at 100M
// - Forced jam latches bit 2 at 100M
// - Bit 1 shows fast link up
// - Bit 0 shows slow link up
`timescale 1ns/1ns

module phy_next_page_and_status_regs
  import phy_np_status_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  // Management access
  input  wire mgmt_req_s   i_mgmt,
  output logic [15:0]      o_rdata,
  output logic             o_rvalid,
  // Datapath inputs
  input  wire dp_events_s  i_events,
  input  wire dp_levels_s  i_levels,
  input  wire logic        i_polarity_fix_enable,
  // Page contents toward the arbitration function
  output logic [15:0]      o_next_page_word
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0]            npt;
    logic                   toggle;
    logic [NUM_LATCHED-1:0] latched;
    logic [15:0]            rdata;
    logic                   rvalid;
  } state_s;

  state_s state_q;
  state_s state_d;

  logic [NUM_LATCHED-1:0] ev_vec;
  logic [15:0]            status_view;

  // Decode used for both read and write paths
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  always_comb begin
    ev_vec[5] = i_events.missing_delimiter & ~i_levels.speed_100;
    ev_vec[4] = i_events.code_violation & ~i_levels.speed_100;
    ev_vec[3] = i_events.disconnect & i_levels.speed_100;
    ev_vec[2] = i_events.scrambler_unlock & i_levels.speed_100;
    ev_vec[1] = i_events.false_carrier & i_levels.speed_100;
    ev_vec[0] = i_events.forced_jam & i_levels.speed_100;
  end

  // ---------------------------------------------------------------
  // Read view of the status register
  // ---------------------------------------------------------------
  always_comb begin
    status_view                    = DLS_RESET;
    status_view[DLS_MISSING_DELIM] = state_q.latched[5];
    status_view[DLS_CODE_VIOL]     = state_q.latched[4];
    // Meaningless at 100M, so masked there
    status_view[DLS_POLARITY]      = i_polarity_fix_enable & i_levels.polarity_reversed
                                     & ~i_levels.speed_100;
    status_view[DLS_DISCONNECT]    = state_q.latched[3];
    status_view[DLS_UNLOCKED]      = state_q.latched[2];
    status_view[DLS_FALSE_CARRIER] = state_q.latched[1];
    status_view[DLS_FORCED_JAM]    = state_q.latched[0];
    status_view[DLS_FAST_LINK]     = i_levels.fast_link_up;
    status_view[DLS_SLOW_LINK]     = i_levels.slow_link_up;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d        = state_q;
    state_d.rvalid = 1'b0;
    // Writable fields only; bits 14 and 11 and the whole status register drop writes
    if (i_mgmt.wr && hit(i_mgmt.addr, NPT_ADDR)) begin
      state_d.npt = i_mgmt.wdata & NPT_WRITE_MASK;
    end
    // Toggle: first page inverts base word bit 11, later pages invert the last one
    if (i_levels.page_exchanged) begin
      state_d.toggle = ~i_levels.lcw_toggle;
    end else if (i_levels.base_sent) begin
      state_d.toggle = ~i_levels.base_toggle;
    end
    if (i_mgmt.rd) begin
      state_d.rvalid = 1'b1;
      if (hit(i_mgmt.addr, NPT_ADDR)) begin
        state_d.rdata = o_next_page_word;
      end else if (hit(i_mgmt.addr, DLS_ADDR)) begin
        state_d.rdata = status_view;
        // Clear on read, but a same-cycle event stays set
        state_d.latched = ev_vec;
      end else begin
        state_d.rdata = 16'h0000;
      end
    end
    // Events always win over a clear
    state_d.latched = state_d.latched | ev_vec;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q.npt     <= NPT_RESET;
      state_q.toggle  <= 1'b0;
      state_q.latched <= '0;
      state_q.rdata   <= 16'h0000;
      state_q.rvalid  <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    o_next_page_word                 = state_q.npt;
    o_next_page_word[NPT_ACK_BIT]    = i_levels.lcw_ack;
    o_next_page_word[NPT_TOGGLE_BIT] = state_q.toggle;
  end

  assign o_rdata  = state_q.rdata;
  assign o_rvalid = state_q.rvalid;

endmodule

// [verification/phy_regs_sva.sv]
// Checker: port relations of the page and status registers
`timescale 1ns/1ns
module phy_regs_sva import phy_np_status_pkg::*; (
  input logic        i_clk,
  input logic        i_reset_n,
  input logic        i_clk_en,
  input mgmt_req_s   i_mgmt,
  input logic [15:0] o_rdata,
  input logic        o_rvalid,
  input dp_events_s  i_events,
  input dp_levels_s  i_levels,
  input logic        i_polarity_fix_enable,
  input logic [15:0] o_next_page_word
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic rs;
  logic ws;
  assign rs = i_clk_en && i_mgmt.rd && i_mgmt.addr == DLS_ADDR;
  assign ws = i_clk_en && i_mgmt.wr && i_mgmt.addr == NPT_ADDR;
  a_ack_live: assert property (o_next_page_word[14] == i_levels.lcw_ack)
    else $error("ack bit");
  a_write_fields: assert property (ws |=>
    (o_next_page_word & NPT_WRITE_MASK) == ($past(i_mgmt.wdata) & NPT_WRITE_MASK))
    else $error("write fields");
  a_toggle_exch: assert property (i_clk_en && i_levels.page_exchanged |=>
    o_next_page_word[11] != $past(i_levels.lcw_toggle)) else $error("toggle exch");
  a_toggle_base: assert property (i_clk_en && i_levels.base_sent &&
    !i_levels.page_exchanged |=> o_next_page_word[11] != $past(i_levels.base_toggle))
    else $error("toggle base");
  a_bad_frame: assert property (i_clk_en && !i_levels.speed_100 &&
    i_events.missing_delimiter ##1 rs |=> o_rvalid && o_rdata[8]) else $error("bad frame");
  a_disconnect_latch: assert property (i_clk_en && i_levels.speed_100 &&
    i_events.disconnect ##1 rs |=> o_rdata[5]) else $error("disconnect");
  a_clear_read: assert property (rs && i_events == 6'h00 ##1
    i_events == 6'h00 ##1 rs |=> o_rdata[8:7] == 2'h0 && o_rdata[5:2] == 4'h0)
    else $error("no clear");
  a_set_wins: assert property (rs && i_levels.speed_100 && i_events.disconnect ##1
    !rs ##1 rs |=> o_rdata[5]) else $error("event lost in clear");
  a_link_levels: assert property (rs |=> o_rdata[15:9] == 7'h00 &&
    o_rdata[1:0] == {$past(i_levels.fast_link_up), $past(i_levels.slow_link_up)})
    else $error("levels");
endmodule

bind phy_next_page_and_status_regs phy_regs_sva i_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_clk_en(i_clk_en), .i_mgmt(i_mgmt), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_events(i_events), .i_levels(i_levels), .i_polarity_fix_enable(i_polarity_fix_enable),
  .o_next_page_word(o_next_page_word));

// [verification/mgmt_station.sv]
// Partner: station controller issuing one-cycle management strobes
`timescale 1ns/1ns
module mgmt_station import phy_np_status_pkg::*; (
  input  logic        i_clk,
  input  logic        i_rvalid,
  input  logic [15:0] i_rdata,
  output mgmt_req_s   o_mgmt
);
  initial o_mgmt = '0;
  // Read data only counts with the answer strobe; otherwise unknown
  task automatic access(input logic r, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    o_mgmt = '{r, !r, a, d};
    @(posedge i_clk);
    #1;
    q = i_rvalid ? i_rdata : 16'hxxxx;
    o_mgmt = '{1'b0, 1'b0, a, ~d};
    @(posedge i_clk);
    #1;
  endtask
endmodule

// [verification/tb.sv]
// Testbench: management reads and writes against the page/status bank
`timescale 1ns/1ns
module tb import phy_np_status_pkg::*; ;
  logic        i_clk = 0;
  logic        i_reset_n = 0;
  logic        fix = 0;
  logic        clk_en = 1'b1;
  dp_events_s  ev = '0;
  dp_levels_s  lv = '0;
  mgmt_req_s   mg;
  logic [15:0] rdata;
  logic [15:0] npw;
  logic [15:0] q;
  logic        rvalid;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      close_out();
    end
  end
  phy_next_page_and_status_regs i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(clk_en),
    .i_mgmt(mg), .o_rdata(rdata), .o_rvalid(rvalid), .i_events(ev), .i_levels(lv),
    .i_polarity_fix_enable(fix), .o_next_page_word(npw));
  mgmt_station i_sta (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_mgmt(mg));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    i_sta.access(1'b1, a, 16'h0000, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_sta.access(1'b0, a, d, q);
  endtask
  // Events last exactly one cycle, then the read follows at once
  task automatic pulse(input dp_events_s v, input logic px, input logic bs);
    ev = v;
    lv.page_exchanged = px;
    lv.base_sent = bs;
    @(posedge i_clk);
    #1;
    ev = '0;
    lv.page_exchanged = 1'b0;
    lv.base_sent = 1'b0;
  endtask
  task automatic close_out();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    lv.lcw_ack = 1'b1;
    rd(NPT_ADDR, 16'h4000);
    rd(DLS_ADDR, 16'h0000);
    wr(NPT_ADDR, 16'hffff);
    chk(npw, 16'hf7ff);
    rd(NPT_ADDR, 16'hf7ff);
    wr(NPT_ADDR, 16'h0000);
    lv.lcw_ack = 1'b0;
    pulse('0, 1'b0, 1'b1);
    rd(NPT_ADDR, 16'h0800);
    lv.lcw_toggle = 1'b1;
    pulse('0, 1'b1, 1'b1);
    rd(NPT_ADDR, 16'h0000);
    fix = 1'b1;
    lv.polarity_reversed = 1'b1;
    lv.slow_link_up = 1'b1;
    pulse('1, 1'b0, 1'b0);
    rd(DLS_ADDR, 16'h01c1);
    wr(DLS_ADDR, 16'hffff);
    rd(DLS_ADDR, 16'h0041);
    fix = 1'b0;
    rd(DLS_ADDR, 16'h0001);
    lv.speed_100 = 1'b1;
    lv.slow_link_up = 1'b0;
    lv.fast_link_up = 1'b1;
    pulse('1, 1'b0, 1'b0);
    rd(DLS_ADDR, 16'h003e);
    rd(DLS_ADDR, 16'h0002);
    // Event inside the clearing read must survive it
    fork
      pulse(6'h08, 1'b0, 1'b0);
      rd(DLS_ADDR, 16'h0002);
    join
    rd(DLS_ADDR, 16'h0022);
    // Reset in mid-run clears page word and flags
    wr(NPT_ADDR, 16'h2abc);
    pulse(6'h08, 1'b0, 1'b0);
    i_reset_n = 1'b0;
    @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    rd(NPT_ADDR, 16'h0000);
    rd(DLS_ADDR, 16'h0002);
    // Low clock enable drops strobes and events alike
    clk_en = 1'b0;
    fork
      wr(NPT_ADDR, 16'h0155);
      pulse(6'h08, 1'b0, 1'b0);
    join
    clk_en = 1'b1;
    rd(NPT_ADDR, 16'h0000);
    rd(DLS_ADDR, 16'h0002);
    rd(5'h00, 16'h0000);
    close_out();
  end
endmodule
